// *** src/xrb_reset_ctrl.sv ***
// Behaviour
// - hold pll reset at least 1 us
// - other resets and ref lock held meanwhile
// - pll locks to reference after release
// - release tx digital reset after lock
// - two cycles after busy, release rx analog
// - wait ref-to-data interval, then lock-to-data
// - lock-to-data request puts cdr on data
// - wait data-lock interval, release rx digital
// - done rises after one clean pattern cycle
// - error held at least three cycles
// - digital resets clear generator and verifier
// - serial loopback feeds generator to verifier
// - low-frequency pattern has no checker
// - gigabit mode sends three commas first
// - odd data count before sync comma
// - one instance per channel, repeated sequence
`include "xrb_defines.svh"

module xrb_reset_ctrl (
	input wire logic clk,
	input wire logic reset,
	xrb_link_if.ctrl link,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	input wire logic [9:0] user_tx_data,
	output logic user_tx_ready,
	output logic [xrb_pkg::XRB_S_READY:0] unused_never
);
	import xrb_pkg::*;

	// ==========================================
	// bus slave
	logic ack_q;
	logic wr_take;
	logic rd_take;
	logic [31:0] readdata_q;
	logic gige_q;
	logic loopback_q;
	xrb_bist_type bist_q;
	logic restart;
	logic [3:0] irq_stat_q;
	logic [3:0] irq_mask_q;
	logic [15:0] ltr_wait_q;
	logic [15:0] ltd_wait_q;
	logic [3:0] events;
	xrb_state_type state_q;
	xrb_state_type state_d;

	assign unused_never = '0;
	// one wait state keeps read data registered
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign wr_take = avs_write && ack_q;
	assign rd_take = avs_read && !ack_q;
	assign restart = wr_take && avs_address == `XRB_REG_CTRL && avs_writedata[`XRB_CTRL_RESTART];

	always_ff @(posedge clk) begin
		if (reset) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read || avs_write) && !ack_q;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			gige_q <= 1'b0;
			loopback_q <= 1'b0;
			bist_q <= XRB_BIST_OFF;
			irq_mask_q <= 4'h0;
			ltr_wait_q <= `XRB_WAIT_RESET;
			ltd_wait_q <= `XRB_WAIT_RESET;
		end else if (wr_take) begin
			if (avs_address == `XRB_REG_CTRL) begin
				gige_q <= avs_writedata[`XRB_CTRL_GIGE];
				loopback_q <= avs_writedata[`XRB_CTRL_LOOPBACK];
				bist_q <= xrb_bist_type'(avs_writedata[`XRB_CTRL_BIST_LO +: 2]);
			end else if (avs_address == `XRB_REG_IRQ_MASK) begin
				irq_mask_q <= avs_writedata[3:0];
			end else if (avs_address == `XRB_REG_LTR_WAIT) begin
				ltr_wait_q <= avs_writedata[15:0];
			end else if (avs_address == `XRB_REG_LTD_WAIT) begin
				ltd_wait_q <= avs_writedata[15:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			readdata_q <= 32'h0000_0000;
		end else if (rd_take) begin
			if (avs_address == `XRB_REG_CTRL) begin
				readdata_q <= {27'h0, bist_q, loopback_q, gige_q, 1'b0};
			end else if (avs_address == `XRB_REG_STATUS) begin
				readdata_q <= {22'h0, state_q == XRB_S_READY, link.bist_err, link.bist_done,
					link.rx_freqlocked, link.busy, link.pll_locked, 1'b0, state_q};
			end else if (avs_address == `XRB_REG_IRQ_STAT) begin
				readdata_q <= {28'h0, irq_stat_q};
			end else if (avs_address == `XRB_REG_IRQ_MASK) begin
				readdata_q <= {28'h0, irq_mask_q};
			end else if (avs_address == `XRB_REG_LTR_WAIT) begin
				readdata_q <= {16'h0, ltr_wait_q};
			end else if (avs_address == `XRB_REG_LTD_WAIT) begin
				readdata_q <= {16'h0, ltd_wait_q};
			end else begin
				readdata_q <= 32'h0000_0000;
			end
		end
	end
	assign avs_readdata = readdata_q;

	// ==========================================
	// interrupts
	logic bist_err_q;
	logic bist_done_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			bist_err_q <= 1'b0;
			bist_done_q <= 1'b0;
		end else begin
			bist_err_q <= link.bist_err;
			bist_done_q <= link.bist_done;
		end
	end

	assign events[`XRB_IRQ_READY] = state_d == XRB_S_READY && state_q != XRB_S_READY;
	assign events[`XRB_IRQ_LOCK_LOST] = state_q != XRB_S_PLL_RST && state_q != XRB_S_WAIT_LOCK
		&& !link.pll_locked;
	assign events[`XRB_IRQ_BIST_ERR] = link.bist_err && !bist_err_q;
	assign events[`XRB_IRQ_BIST_DONE] = link.bist_done && !bist_done_q;

	// a new event beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_stat_q <= 4'h0;
		end else if (wr_take && avs_address == `XRB_REG_IRQ_STAT) begin
			irq_stat_q <= (irq_stat_q & ~avs_writedata[3:0]) | events;
		end else begin
			irq_stat_q <= irq_stat_q | events;
		end
	end
	assign irq = |(irq_stat_q & irq_mask_q);

	// ==========================================
	// reset sequencer
	logic [15:0] cnt_q;
	logic [15:0] ltr_eff;
	logic [15:0] ltd_eff;

	// software may lengthen the waits but not cut them short
	assign ltr_eff = ltr_wait_q < 16'(`XRB_LTR_MIN_CYC) ? 16'(`XRB_LTR_MIN_CYC) : ltr_wait_q;
	assign ltd_eff = ltd_wait_q < 16'(`XRB_LTD_MIN_CYC) ? 16'(`XRB_LTD_MIN_CYC) : ltd_wait_q;

	// one channel per instance; non-bonded links use one instance each
	always_comb begin
		state_d = state_q;
		case (state_q)
			XRB_S_PLL_RST: begin
				if (cnt_q >= 16'(`XRB_PLL_RST_CYC - 1)) begin
					state_d = XRB_S_WAIT_LOCK;
				end
			end
			XRB_S_WAIT_LOCK: begin
				if (link.pll_locked) begin
					state_d = XRB_S_WAIT_BUSY;
				end
			end
			XRB_S_WAIT_BUSY: begin
				if (!link.busy) begin
					state_d = XRB_S_RX_ANA;
				end
			end
			XRB_S_RX_ANA: begin
				if (cnt_q >= 16'(`XRB_RX_ANA_WAIT_CYC - 1)) begin
					state_d = XRB_S_WAIT_LTR;
				end
			end
			XRB_S_WAIT_LTR: begin
				if (cnt_q >= ltr_eff - 16'h0001) begin
					state_d = XRB_S_WAIT_LTD;
				end
			end
			XRB_S_WAIT_LTD: begin
				if (cnt_q >= ltd_eff - 16'h0001) begin
					state_d = XRB_S_READY;
				end
			end
			default: begin
				state_d = XRB_S_READY;
			end
		endcase
		if (restart || events[`XRB_IRQ_LOCK_LOST]) begin
			state_d = XRB_S_PLL_RST;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= XRB_S_PLL_RST;
			cnt_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			cnt_q <= (state_d != state_q || restart) ? 16'h0000 : cnt_q + 16'h0001;
		end
	end

	// ==========================================
	// channel resets registered from the next state; mode bits straight from their registers
	always_ff @(posedge clk) begin
		if (reset) begin
			link.pll_areset <= 1'b1;
			link.tx_digitalreset <= 1'b1;
			link.rx_analogreset <= 1'b1;
			link.rx_digitalreset <= 1'b1;
			link.rx_locktorefclk <= 1'b1;
			link.rx_locktodata <= 1'b0;
		end else begin
			link.pll_areset <= state_d == XRB_S_PLL_RST;
			link.tx_digitalreset <= state_d == XRB_S_PLL_RST || state_d == XRB_S_WAIT_LOCK;
			link.rx_analogreset <= state_d < XRB_S_WAIT_LTR;
			link.rx_digitalreset <= state_d != XRB_S_READY;
			link.rx_locktorefclk <= state_d < XRB_S_WAIT_LTD;
			link.rx_locktodata <= state_d >= XRB_S_WAIT_LTD;
		end
	end

	assign link.gige_mode = gige_q;
	assign link.serial_loopback = loopback_q;
	assign link.bist_mode = bist_q;

	// ==========================================
	// transmit filler after the automatic commas
	logic [1:0] fill_cnt_q;
	logic [1:0] fill_d;
	logic [9:0] tx_data_q;

	// an odd filler run keeps the user's first comma on an even boundary
	always_comb begin
		fill_d = fill_cnt_q;
		if (link.tx_digitalreset) begin
			fill_d = gige_q ? 2'(`XRB_FILL_COUNT) : 2'h0;
		end else if (link.tx_ready && fill_cnt_q != 2'h0) begin
			fill_d = fill_cnt_q - 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		fill_cnt_q <= reset ? 2'h0 : fill_d;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			tx_data_q <= 10'h000;
		end else begin
			tx_data_q <= fill_d != 2'h0 ? `XRB_FILL_WORD : user_tx_data;
		end
	end

	assign link.tx_data = tx_data_q;
	assign user_tx_ready = link.tx_ready && fill_d == 2'h0;
endmodule // xrb_reset_ctrl

// *** shared/xrb_defines.svh ***
`ifndef XRB_DEFINES_SVH
`define XRB_DEFINES_SVH

// ==========================================
// clock and timing
`define XRB_CLK_MHZ 125
`define XRB_PLL_RST_NS 1000
`define XRB_PLL_RST_CYC ((`XRB_PLL_RST_NS * `XRB_CLK_MHZ + 999) / 1000)
`define XRB_RX_ANA_WAIT_CYC 2
`define XRB_LTR_MIN_NS 4000
`define XRB_LTR_MIN_CYC ((`XRB_LTR_MIN_NS * `XRB_CLK_MHZ + 999) / 1000)
`define XRB_LTD_MIN_NS 4000
`define XRB_LTD_MIN_CYC ((`XRB_LTD_MIN_NS * `XRB_CLK_MHZ + 999) / 1000)
`define XRB_PLL_LOCK_CYC 64
`define XRB_BUSY_CYC 16
`define XRB_CDR_LOCK_CYC 32

// ==========================================
// pattern and comma figures
`define XRB_COMMA_COUNT 3
`define XRB_COMMA_WORD 10'h0FA
`define XRB_LOW_FREQ_WORD 10'h3E0
`define XRB_FILL_WORD 10'h2AA
`define XRB_FILL_COUNT 1
`define XRB_PAT_LEN 127
`define XRB_ERR_MIN_CYC 3

// ==========================================
// register word indices
`define XRB_REG_CTRL 3'h0
`define XRB_REG_STATUS 3'h1
`define XRB_REG_IRQ_STAT 3'h2
`define XRB_REG_IRQ_MASK 3'h3
`define XRB_REG_LTR_WAIT 3'h4
`define XRB_REG_LTD_WAIT 3'h5

// ==========================================
// field positions and wait reset value
`define XRB_CTRL_RESTART 0
`define XRB_CTRL_GIGE 1
`define XRB_CTRL_LOOPBACK 2
`define XRB_CTRL_BIST_LO 3
`define XRB_IRQ_READY 0
`define XRB_IRQ_LOCK_LOST 1
`define XRB_IRQ_BIST_ERR 2
`define XRB_IRQ_BIST_DONE 3
`define XRB_WAIT_RESET 16'h0200

`endif

// *** shared/xrb_pkg.sv ***
package xrb_pkg;
	typedef enum logic [2:0] {
		XRB_S_PLL_RST = 3'b000,
		XRB_S_WAIT_LOCK = 3'b001,
		XRB_S_WAIT_BUSY = 3'b010,
		XRB_S_RX_ANA = 3'b011,
		XRB_S_WAIT_LTR = 3'b100,
		XRB_S_WAIT_LTD = 3'b101,
		XRB_S_READY = 3'b110
	} xrb_state_type;

	typedef enum logic [1:0] {
		XRB_BIST_OFF = 2'b00,
		XRB_BIST_PRBS = 2'b01,
		XRB_BIST_LOW_FREQ = 2'b10
	} xrb_bist_type;
endpackage

// *** shared/xrb_link_if.sv ***
interface xrb_link_if;
	import xrb_pkg::*;
	logic pll_areset;
	logic pll_locked;
	logic busy;
	logic tx_digitalreset;
	logic rx_analogreset;
	logic rx_digitalreset;
	logic rx_locktorefclk;
	logic rx_locktodata;
	logic rx_freqlocked;
	logic gige_mode;
	logic serial_loopback;
	xrb_bist_type bist_mode;
	logic [9:0] tx_data;
	logic tx_ready;
	logic bist_done;
	logic bist_err;

	modport channel (
		input pll_areset, tx_digitalreset, rx_analogreset, rx_digitalreset,
		input rx_locktorefclk, rx_locktodata, gige_mode, serial_loopback, bist_mode, tx_data,
		output pll_locked, busy, rx_freqlocked, tx_ready, bist_done, bist_err
	);
	modport ctrl (
		output pll_areset, tx_digitalreset, rx_analogreset, rx_digitalreset,
		output rx_locktorefclk, rx_locktodata, gige_mode, serial_loopback, bist_mode, tx_data,
		input pll_locked, busy, rx_freqlocked, tx_ready, bist_done, bist_err
	);
endinterface

// *** src/xrb_channel.sv ***
`include "xrb_defines.svh"

module xrb_channel (
	input wire logic clk,
	input wire logic reset,
	xrb_link_if.channel link,
	output logic [9:0] serial_tx_word,
	input wire logic [9:0] serial_rx_word
);
	import xrb_pkg::*;

	function automatic logic [6:0] prbs_step(input logic [6:0] s);
		prbs_step = {s[5:0], s[6] ^ s[5]};
	endfunction

	function automatic logic [9:0] prbs_word(input logic [6:0] s);
		prbs_word = {s, s[6:4]};
	endfunction

	// ==========================================
	// pll, busy and cdr
	logic [7:0] lock_cnt_q;
	logic [7:0] busy_cnt_q;
	logic [7:0] cdr_cnt_q;
	logic pll_locked_q;
	logic busy_q;
	logic freqlocked_q;

	always_ff @(posedge clk) begin
		if (reset || link.pll_areset) begin
			lock_cnt_q <= 8'h00;
			pll_locked_q <= 1'b0;
		end else if (lock_cnt_q == 8'(`XRB_PLL_LOCK_CYC)) begin
			pll_locked_q <= 1'b1;
		end else begin
			lock_cnt_q <= lock_cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || link.pll_areset || !pll_locked_q) begin
			busy_cnt_q <= 8'h00;
			busy_q <= 1'b1;
		end else if (busy_cnt_q == 8'(`XRB_BUSY_CYC)) begin
			busy_q <= 1'b0;
		end else begin
			busy_cnt_q <= busy_cnt_q + 8'h01;
		end
	end

	// lock-to-data only counts while the reference request is dropped
	always_ff @(posedge clk) begin
		if (reset || link.rx_analogreset || !link.rx_locktodata || link.rx_locktorefclk) begin
			cdr_cnt_q <= 8'h00;
			freqlocked_q <= 1'b0;
		end else if (cdr_cnt_q == 8'(`XRB_CDR_LOCK_CYC)) begin
			freqlocked_q <= 1'b1;
		end else begin
			cdr_cnt_q <= cdr_cnt_q + 8'h01;
		end
	end

	// ==========================================
	// transmit path
	logic [1:0] comma_cnt_q;
	logic [6:0] gen_q;
	logic [9:0] tx_word_q;
	logic comma_now;

	assign comma_now = link.gige_mode && comma_cnt_q != 2'h0;

	always_ff @(posedge clk) begin
		if (reset || link.tx_digitalreset) begin
			comma_cnt_q <= 2'(`XRB_COMMA_COUNT);
		end else if (comma_now) begin
			comma_cnt_q <= comma_cnt_q - 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || link.tx_digitalreset) begin
			gen_q <= 7'h7F;
		end else begin
			gen_q <= prbs_step(gen_q);
		end
	end

	always_ff @(posedge clk) begin
		if (reset || link.tx_digitalreset) begin
			tx_word_q <= 10'h000;
		end else if (link.bist_mode == XRB_BIST_PRBS) begin
			tx_word_q <= prbs_word(gen_q);
		end else if (link.bist_mode == XRB_BIST_LOW_FREQ) begin
			tx_word_q <= `XRB_LOW_FREQ_WORD;
		end else if (comma_now) begin
			tx_word_q <= `XRB_COMMA_WORD;
		end else begin
			tx_word_q <= link.tx_data;
		end
	end

	assign link.tx_ready = !link.tx_digitalreset && link.bist_mode == XRB_BIST_OFF && !comma_now;
	assign serial_tx_word = tx_word_q;

	// ==========================================
	// verifier
	logic [9:0] rx_word;
	logic [6:0] ver_q;
	logic seeded_q;
	logic [6:0] run_cnt_q;
	logic [1:0] err_hold_q;
	logic done_q;
	logic err_q;
	logic match;

	assign rx_word = link.serial_loopback ? tx_word_q : serial_rx_word;
	assign match = rx_word == prbs_word(ver_q);

	// low-frequency pattern has no checker, so its flags stay low
	always_ff @(posedge clk) begin
		if (reset || link.rx_digitalreset || link.bist_mode != XRB_BIST_PRBS) begin
			ver_q <= 7'h00;
			seeded_q <= 1'b0;
			run_cnt_q <= 7'h00;
			err_hold_q <= 2'h0;
			done_q <= 1'b0;
			err_q <= 1'b0;
		end else if (!seeded_q || (!done_q && !match)) begin
			ver_q <= prbs_step(rx_word[9:3]);
			seeded_q <= 1'b1;
			run_cnt_q <= 7'h00;
		end else begin
			ver_q <= prbs_step(ver_q);
			run_cnt_q <= (!match || run_cnt_q == 7'(`XRB_PAT_LEN)) ? 7'h00 : run_cnt_q + 7'h01;
			if (!done_q && run_cnt_q == 7'(`XRB_PAT_LEN - 1)) begin
				done_q <= 1'b1;
			end
			if (done_q && !match) begin
				err_q <= 1'b1;
				err_hold_q <= 2'(`XRB_ERR_MIN_CYC - 1);
			end else if (err_hold_q != 2'h0) begin
				err_hold_q <= err_hold_q - 2'h1;
			end else if (run_cnt_q == 7'(`XRB_PAT_LEN - 1)) begin
				err_q <= 1'b0;
			end
		end
	end

	assign link.pll_locked = pll_locked_q;
	assign link.busy = busy_q;
	assign link.rx_freqlocked = freqlocked_q;
	assign link.bist_done = done_q;
	assign link.bist_err = err_q;
endmodule // xrb_channel

// *** sim/xrb_link_monitor.sv ***
module xrb_link_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic pll_areset,
	input wire logic pll_locked,
	input wire logic busy,
	input wire logic tx_digitalreset,
	input wire logic rx_analogreset,
	input wire logic rx_digitalreset,
	input wire logic rx_locktorefclk,
	input wire logic rx_locktodata,
	input wire logic gige_mode,
	input wire logic tx_ready,
	input wire logic bist_done,
	input wire logic bist_err,
	input wire xrb_pkg::xrb_bist_type bist_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	import xrb_pkg::*;

	logic [15:0] hold_q;
	logic [15:0] ltr_q;
	logic [15:0] ltd_q;

	// ==========================================
	// wait counters, cleared whenever their phase is left
	always_ff @(posedge clk) begin
		hold_q <= (reset || !pll_areset) ? 16'h0000 : hold_q + 16'h0001;
	end
	always_ff @(posedge clk) begin
		ltr_q <= (reset || rx_analogreset || !rx_locktorefclk) ? 16'h0000 : ltr_q + 16'h0001;
	end
	always_ff @(posedge clk) begin
		ltd_q <= (reset || !rx_locktodata || !rx_digitalreset) ? 16'h0000 : ltd_q + 16'h0001;
	end

	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// ==========================================
	// sequence checks
	pll_hold_a: assert property ($fell(pll_areset) |-> hold_q >= 16'h007D)
		else $error("pll reset released too early");
	reset_group_a: assert property (pll_areset |-> tx_digitalreset && rx_analogreset
		&& rx_digitalreset && rx_locktorefclk && !rx_locktodata)
		else $error("channel resets not held during pll reset");
	pll_lock_a: assert property ($fell(pll_areset) |-> ##[1:100] pll_locked)
		else $error("pll did not lock");
	tx_after_lock_a: assert property ($fell(tx_digitalreset) |-> $past(pll_locked) && pll_locked)
		else $error("tx reset released before lock");
	rx_ana_wait_a: assert property ($fell(rx_analogreset) |-> !$past(busy) && !$past(busy, 2))
		else $error("rx analog reset released too soon after busy");
	data_swap_a: assert property ($rose(rx_locktodata) |-> $fell(rx_locktorefclk)
		&& ltr_q >= 16'h01F4)
		else $error("lock-to-data too early or not paired");
	rx_dig_wait_a: assert property ($fell(rx_digitalreset) |-> rx_locktodata
		&& ltd_q >= 16'h01F4)
		else $error("rx digital reset released too early");
	done_clear_a: assert property (rx_digitalreset && $past(rx_digitalreset) |-> !bist_done)
		else $error("done flag high while verifier in reset");
	err_hold_a: assert property ($rose(bist_err) |-> bist_err [*3])
		else $error("error flag shorter than three cycles");
	low_freq_a: assert property (bist_mode == XRB_BIST_LOW_FREQ
		&& $past(bist_mode) == XRB_BIST_LOW_FREQ && $past(bist_mode, 2) == XRB_BIST_LOW_FREQ
		|-> !bist_done && !bist_err)
		else $error("verifier flags active on low-frequency pattern");
	comma_gap_a: assert property ($fell(tx_digitalreset) && gige_mode |-> !tx_ready [*3])
		else $error("user data allowed before commas");

	ready_c: cover property ($fell(rx_digitalreset));
	done_c: cover property ($rose(bist_done));
	err_c: cover property ($rose(bist_err));
	restart_c: cover property ($rose(pll_areset));
endmodule // xrb_link_monitor

// *** sim/tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import xrb_pkg::*;

	logic clk;
	logic reset;
	logic [2:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic [31:0] rd;
	logic avs_waitrequest;
	logic irq;
	logic user_tx_ready;
	logic [9:0] user_tx_data;
	logic [9:0] serial_tx_word;
	logic [9:0] serial_rx_word;
	logic [9:0] exp_w [4] = '{10'h0FA, 10'h0FA, 10'h2AA, 10'h0FA};
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int ltr_n = 0;
	int ltd_n = 0;

	xrb_link_if link();

	xrb_channel u_xrb_channel (.clk(clk), .reset(reset), .link(link.channel),
		.serial_tx_word(serial_tx_word), .serial_rx_word(serial_rx_word));
	xrb_reset_ctrl u_xrb_reset_ctrl (.clk(clk), .reset(reset), .link(link.ctrl),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .user_tx_data(user_tx_data),
		.user_tx_ready(user_tx_ready), .unused_never());
	xrb_link_monitor u_xrb_link_monitor (.clk(clk), .reset(reset),
		.pll_areset(link.pll_areset), .pll_locked(link.pll_locked), .busy(link.busy),
		.tx_digitalreset(link.tx_digitalreset), .rx_analogreset(link.rx_analogreset),
		.rx_digitalreset(link.rx_digitalreset), .rx_locktorefclk(link.rx_locktorefclk),
		.rx_locktodata(link.rx_locktodata), .gige_mode(link.gige_mode),
		.tx_ready(link.tx_ready), .bist_done(link.bist_done), .bist_err(link.bist_err),
		.bist_mode(link.bist_mode));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ==========================================
	// phase lengths sampled mid-cycle, away from the updating edge
	always @(negedge clk) begin
		cyc <= cyc + 1;
		if (!link.rx_analogreset && link.rx_locktorefclk) ltr_n <= ltr_n + 1;
		if (link.rx_locktodata && link.rx_digitalreset) ltd_n <= ltd_n + 1;
		if (cyc == 30000) begin
			err_count++;
			finish_test();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one access; request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ==========================================
	// main sequence
	initial begin
		reset = 1'b1;
		avs_address = 3'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		user_tx_data = 10'h0FA;
		serial_rx_word = 10'h000;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		bus(1'b0, 3'h4, 32'h0);
		check("ltr default", rd, 32'h00000200);
		bus(1'b0, 3'h3, 32'h0);
		check("mask default", rd, 32'h00000000);
		bus(1'b1, 3'h7, 32'hFFFFFFFF);
		bus(1'b0, 3'h7, 32'h0);
		check("unmapped", rd, 32'h00000000);
		bus(1'b1, 3'h4, 32'h00000258);
		bus(1'b1, 3'h5, 32'h00000010);
		do @(negedge clk); while (link.rx_digitalreset !== 1'b0);
		@(posedge clk);
		check("ltr span", 32'(ltr_n >= 599 && ltr_n <= 602), 32'h1);
		check("ltd span", 32'(ltd_n >= 499 && ltd_n <= 502), 32'h1);
		bus(1'b0, 3'h1, 32'h0);
		check("status ready", rd & 32'h00000277, 32'h00000256);
		bus(1'b0, 3'h2, 32'h0);
		check("ready event", rd & 32'h00000001, 32'h00000001);
		bus(1'b1, 3'h3, 32'h0000000F);
		check("irq on", 32'(irq), 32'h1);
		bus(1'b1, 3'h3, 32'h00000000);
		check("irq masking", 32'(irq), 32'h0);
		bus(1'b1, 3'h2, 32'h00000001);
		bus(1'b0, 3'h2, 32'h0);
		check("event cleared", rd & 32'h00000001, 32'h00000000);
		check("irq idle", 32'(irq), 32'h0);
		// restart in gigabit mode; user sends a comma at once
		bus(1'b1, 3'h0, 32'h00000003);
		do @(negedge clk); while (link.tx_digitalreset !== 1'b0);
		do @(negedge clk); while (serial_tx_word !== 10'h0FA);
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			check("tx word", 32'(serial_tx_word), 32'(exp_w[i]));
		end
		check("user ready", 32'(user_tx_ready), 32'h1);
		do @(negedge clk); while (link.rx_digitalreset !== 1'b0);
		@(posedge clk);
		// prbs through loopback, then a broken line
		bus(1'b1, 3'h0, 32'h0000000C);
		do @(negedge clk); while (link.bist_done !== 1'b1);
		@(posedge clk);
		bus(1'b0, 3'h1, 32'h0);
		check("done status", rd & 32'h00000080, 32'h00000080);
		bus(1'b1, 3'h0, 32'h00000008);
		do @(negedge clk); while (link.bist_err !== 1'b1);
		@(posedge clk);
		bus(1'b0, 3'h2, 32'h0);
		check("err event", rd & 32'h0000000C, 32'h0000000C);
		bus(1'b1, 3'h0, 32'h0000000C);
		do @(negedge clk); while (link.bist_err !== 1'b0);
		check("done sticky", 32'(link.bist_done), 32'h1);
		@(posedge clk);
		bus(1'b1, 3'h0, 32'h0000000D);
		do @(negedge clk); while (link.rx_digitalreset !== 1'b1);
		repeat (2) @(negedge clk);
		check("done reset", 32'(link.bist_done), 32'h0);
		do @(negedge clk); while (link.rx_digitalreset !== 1'b0);
		@(posedge clk);
		// low-frequency pattern has no verifier
		bus(1'b1, 3'h0, 32'h00000014);
		repeat (4) @(negedge clk);
		check("low word", 32'(serial_tx_word), 32'h000003E0);
		check("low flags", 32'({link.bist_done, link.bist_err}), 32'h0);
		finish_test();
	end
endmodule // tb_top
